// ==== design/ebt_pkg.sv ====
package ebt_pkg;

	// ************************************************************
	// Control register field layout
	// ************************************************************
	localparam int unsigned CTL_WIDTH      = 8;
	localparam int unsigned CTL_FF_BIT     = 7;
	localparam int unsigned CTL_CLK_HI     = 6;
	localparam int unsigned CTL_CLK_LO     = 4;
	localparam int unsigned CTL_RUN_BIT    = 3;
	localparam int unsigned CTL_MODE_HI    = 2;
	localparam int unsigned CTL_MODE_LO    = 0;
	localparam logic [7:0]  CTL_RESET      = 8'h00;
	localparam logic [7:0]  CMP_RESET      = 8'hff;
	localparam logic [7:0]  CNT_RESET      = 8'h00;

	// ************************************************************
	// Field encodings
	// ************************************************************
	localparam logic [2:0]  MODE_TIMER     = 3'h0;
	localparam logic [2:0]  MODE_DIVIDER   = 3'h1;

	localparam logic [2:0]  SRC_SLOWEST    = 3'h0;
	localparam logic [2:0]  SRC_DIV7       = 3'h1;
	localparam logic [2:0]  SRC_DIV5       = 3'h2;
	localparam logic [2:0]  SRC_DIV3       = 3'h3;
	localparam logic [2:0]  SRC_EVENT_PIN  = 3'h7;

	// ************************************************************
	// Prescaler taps
	// ************************************************************
	localparam int unsigned PRE_WIDTH      = 11;
	localparam logic [10:0] PRE_MASK_11    = 11'h7ff;
	localparam logic [10:0] PRE_MASK_7     = 11'h07f;
	localparam logic [10:0] PRE_MASK_5     = 11'h01f;
	localparam logic [10:0] PRE_MASK_3     = 11'h007;
	localparam int unsigned SLOW_WIDTH     = 3;
	localparam logic [2:0]  SLOW_MASK_3    = 3'h7;

	typedef enum {
		EBT_IDLE,
		EBT_COUNT,
		EBT_HOLD
	} ebt_state_t;

endpackage : ebt_pkg

// ==== design/ebt_timer.sv ====
`timescale 1ns/1ns
// Behaviour
// - Timer mode: count source clock, match clears, interrupts
// - Compare register takes new value immediately
// - Event mode counts event pin falling edges
// - Event match interrupts, clears, keeps counting
// - Divider mode: match toggles flip-flop, clears, interrupts
// - Divider pin is inverse of flip-flop
// - Flip-flop loadable by software; reset clears it
// - Divider output is square wave, half duty
// - Stopping counter holds divider pin level
// - Bit3 clear stops; bit7 clear stopped drives high
// - Selectable prescaled source; slow mode only fs/8
module ebt_timer (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// Control register write port
	input  wire logic                 ctl_write,
	input  wire logic [7:0]           ctl_wdata,
	// Compare register write port
	input  wire logic                 cmp_write,
	input  wire logic [7:0]           cmp_wdata,
	// System clocking state
	input  wire logic                 fs_tick,
	input  wire logic                 slow_prescale_select,
	input  wire logic                 slow_run_mode,
	// External event source
	input  wire logic                 event_input_pin,
	// Readback
	output logic      [7:0]           timer_control_reg,
	output logic      [7:0]           compare_value_reg,
	output logic      [7:0]           count_value,
	// Events and pins
	output logic                      match_interrupt,
	output logic                      divider_output_pin
);
	import ebt_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	ebt_state_t                state;
	ebt_state_t                next_state;
	logic [7:0]                next_timer_control_reg;
	logic [7:0]                next_compare_value_reg;
	logic [7:0]                next_count_value;
	logic                      next_match_interrupt;
	logic                      next_divider_output_pin;
	logic                      timer_ff;
	logic                      next_timer_ff;
	logic [PRE_WIDTH-1:0]      prescale;
	logic [PRE_WIDTH-1:0]      next_prescale;
	logic [SLOW_WIDTH-1:0]     slow_div;
	logic [SLOW_WIDTH-1:0]     next_slow_div;
	logic                      event_prev;
	logic                      next_event_prev;

	// ************************************************************
	// Decoded control fields
	// ************************************************************
	logic                      run;
	logic [2:0]                mode;
	logic [2:0]                src;
	logic                      ff_init;
	logic                      mode_ok;
	logic                      slow_tick;
	logic                      fc_tick;
	logic                      src_tick;
	logic                      event_fall;
	logic [7:0]                count_inc;
	logic                      cmp_hit;
	logic                      tap_11;
	logic                      tap_7;
	logic                      tap_5;
	logic                      tap_3;

	always_comb begin
		run      = timer_control_reg[CTL_RUN_BIT];
		mode     = timer_control_reg[CTL_MODE_HI:CTL_MODE_LO];
		src      = timer_control_reg[CTL_CLK_HI:CTL_CLK_LO];
		ff_init  = timer_control_reg[CTL_FF_BIT];
		// Only the timer/event and divider modes are built
		mode_ok  = (mode == MODE_TIMER) || (mode == MODE_DIVIDER);
		count_inc = count_value + 8'h01;
		cmp_hit   = (count_inc == compare_value_reg);
	end

	// ************************************************************
	// Prescaler and source selection
	// ************************************************************
	// One tap per internal rate except fs/8, all read from the same free-running prescaler
	ebt_tap #(.WIDTH(PRE_WIDTH), .MASK(PRE_MASK_11)) u_tap_11 (
		.value (prescale),
		.hit   (tap_11)
	);
	ebt_tap #(.WIDTH(PRE_WIDTH), .MASK(PRE_MASK_7)) u_tap_7 (
		.value (prescale),
		.hit   (tap_7)
	);
	ebt_tap #(.WIDTH(PRE_WIDTH), .MASK(PRE_MASK_5)) u_tap_5 (
		.value (prescale),
		.hit   (tap_5)
	);
	ebt_tap #(.WIDTH(PRE_WIDTH), .MASK(PRE_MASK_3)) u_tap_3 (
		.value (prescale),
		.hit   (tap_3)
	);
	always_comb begin
		next_prescale = prescale + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
		next_slow_div = slow_div;
		if (fs_tick) begin
			next_slow_div = slow_div + {{(SLOW_WIDTH-1){1'b0}}, 1'b1};
		end
		next_event_prev = event_input_pin;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale   <= '0;
			slow_div   <= '0;
			event_prev <= 1'b1;
		end else begin
			prescale   <= next_prescale;
			slow_div   <= next_slow_div;
			event_prev <= next_event_prev;
		end
	end

	always_comb begin
		slow_tick  = fs_tick && (slow_div == SLOW_MASK_3);
		// Any high-to-low change between two samples counts; the source guarantees the width
		event_fall = event_prev && !event_input_pin;
		fc_tick    = 1'b0;
		case (src)
			SRC_SLOWEST: begin
				fc_tick = slow_prescale_select ? slow_tick
				                               : tap_11;
			end
			SRC_DIV7: begin
				fc_tick = tap_7;
			end
			SRC_DIV5: begin
				fc_tick = tap_5;
			end
			SRC_DIV3: begin
				fc_tick = tap_3;
			end
			default: begin
				fc_tick = 1'b0;
			end
		endcase
		if (src == SRC_EVENT_PIN) begin
			// Divider mode has no pin source, so it stalls there
			src_tick = (mode == MODE_TIMER) && event_fall;
		end else if (slow_run_mode) begin
			// High-speed taps stop with the fast oscillator
			src_tick = (src == SRC_SLOWEST) && slow_tick;
		end else begin
			src_tick = fc_tick;
		end
	end

	// ************************************************************
	// Register writes
	// ************************************************************
	always_comb begin
		next_timer_control_reg = timer_control_reg;
		next_compare_value_reg = compare_value_reg;
		if (ctl_write) begin
			next_timer_control_reg = ctl_wdata;
		end
		if (cmp_write) begin
			// No shadow stage: the match logic sees it next cycle
			next_compare_value_reg = cmp_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_control_reg <= CTL_RESET;
			compare_value_reg <= CMP_RESET;
		end else begin
			timer_control_reg <= next_timer_control_reg;
			compare_value_reg <= next_compare_value_reg;
		end
	end

	// ************************************************************
	// Counter sequencing
	// ************************************************************
	always_comb begin
		next_state           = state;
		next_count_value     = count_value;
		next_match_interrupt = 1'b0;
		case (state)
			EBT_IDLE: begin
				next_count_value = CNT_RESET;
				if (run && mode_ok) begin
					next_state = EBT_COUNT;
				end
			end
			EBT_COUNT: begin
				if (!run) begin
					// Flip-flop untouched, so the pin keeps its level
					next_state       = EBT_IDLE;
					next_count_value = CNT_RESET;
				end else if (!mode_ok) begin
					next_state       = EBT_HOLD;
				end else if (src_tick) begin
					if (cmp_hit) begin
						next_count_value     = CNT_RESET;
						next_match_interrupt = 1'b1;
					end else begin
						next_count_value = count_inc;
					end
				end
			end
			EBT_HOLD: begin
				// Unbuilt mode selected while running: freeze
				if (!run) begin
					next_state       = EBT_IDLE;
					next_count_value = CNT_RESET;
				end else if (mode_ok) begin
					next_state       = EBT_COUNT;
				end
			end
			default: begin
				next_state       = EBT_IDLE;
				next_count_value = CNT_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state           <= EBT_IDLE;
			count_value     <= CNT_RESET;
			match_interrupt <= 1'b0;
		end else begin
			state           <= next_state;
			count_value     <= next_count_value;
			match_interrupt <= next_match_interrupt;
		end
	end

	// ************************************************************
	// Timer flip-flop and divider pin
	// ************************************************************
	always_comb begin
		next_timer_ff = timer_ff;
		case (state)
			EBT_IDLE: begin
				// Loads on any write while stopped, the start write too
				if (ctl_write) begin
					next_timer_ff = ctl_wdata[CTL_FF_BIT];
				end
			end
			EBT_COUNT: begin
				// A stop never touches it, so the pin keeps its level
				if (run && mode_ok && src_tick && cmp_hit && (mode == MODE_DIVIDER)) begin
					// Equal half periods give the square wave
					next_timer_ff = !timer_ff;
				end
			end
			default: begin
				next_timer_ff = timer_ff;
			end
		endcase
		// Pin registered from the next value so it moves with the flip-flop
		next_divider_output_pin = !next_timer_ff;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_ff           <= 1'b0;
			divider_output_pin <= 1'b1;
		end else begin
			timer_ff           <= next_timer_ff;
			divider_output_pin <= next_divider_output_pin;
		end
	end

endmodule : ebt_timer

// ************************************************************
// Prescaler tap
// ************************************************************
module ebt_tap #(
	parameter int unsigned        WIDTH = 11,
	parameter logic [WIDTH-1:0]   MASK  = '1
) (
	// Prescaler state
	input  wire logic [WIDTH-1:0] value,
	// Strobe
	output logic                  hit
);
	always_comb begin
		hit = ((value & MASK) == MASK);
	end
endmodule : ebt_tap

// ==== test/ebt_event_src.sv ====
`timescale 1ns/1ns
module ebt_event_src #(
	parameter int HALF = 8
) (
	input wire logic clk,
	input wire logic en,
	output logic     event_input_pin = 1'b1
);
	int n = 0;
	// Idle high; each level held two machine cycles, so at most a sixteenth of clk
	always @(posedge clk) begin
		if (!en) begin
			n <= 0;
			event_input_pin <= #5 1'b1;
		end else if (n == HALF - 1) begin
			n <= 0;
			event_input_pin <= #5 ~event_input_pin;
		end else begin
			n <= n + 1;
		end
	end
endmodule : ebt_event_src

// ==== test/ebt_timer_sva.sv ====
`timescale 1ns/1ns
module ebt_timer_chk
	import ebt_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// Writes
	input wire logic       ctl_write,
	input wire logic [7:0] ctl_wdata,
	input wire logic       cmp_write,
	input wire logic [7:0] cmp_wdata,
	// Outputs
	input wire logic [7:0] timer_control_reg,
	input wire logic [7:0] compare_value_reg,
	input wire logic [7:0] count_value,
	input wire logic       match_interrupt,
	input wire logic       divider_output_pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_ctl; ctl_write |=> timer_control_reg == $past(ctl_wdata); endproperty
	a_ctl: assert property (p_ctl) else $error("control readback wrong");
	property p_cmp; cmp_write |=> compare_value_reg == $past(cmp_wdata); endproperty
	a_cmp: assert property (p_cmp) else $error("compare not immediate");
	property p_stop; !timer_control_reg[CTL_RUN_BIT] |=> count_value == CNT_RESET; endproperty
	a_stop: assert property (p_stop) else $error("count not zero when stopped");
	property p_step; $changed(count_value) |-> count_value == 8'h00 || count_value == $past(count_value) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_clr; match_interrupt |-> count_value == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("count not cleared at match");
	property p_cause; $rose(match_interrupt) |-> $past(count_value) + 8'h01 == compare_value_reg; endproperty
	a_cause: assert property (p_cause) else $error("match without compare equality");
	property p_tog; match_interrupt && timer_control_reg[2:0] == MODE_DIVIDER
		|-> divider_output_pin != $past(divider_output_pin); endproperty
	a_tog: assert property (p_tog) else $error("divider pin did not toggle");
	// Writes excluded: a stopped write may load the flip-flop
	property p_hold; !timer_control_reg[CTL_RUN_BIT] && $past(!timer_control_reg[CTL_RUN_BIT]) && !match_interrupt
		&& !ctl_write && !$past(ctl_write) && !$past(ctl_write, 2) |=> $stable(divider_output_pin); endproperty
	a_hold: assert property (p_hold) else $error("pin moved while stopped");
endmodule : ebt_timer_chk

bind ebt_timer ebt_timer_chk u_chk (.clk(clk), .rst_b(rst_b), .ctl_write(ctl_write), .ctl_wdata(ctl_wdata),
	.cmp_write(cmp_write), .cmp_wdata(cmp_wdata), .timer_control_reg(timer_control_reg),
	.compare_value_reg(compare_value_reg), .count_value(count_value), .match_interrupt(match_interrupt),
	.divider_output_pin(divider_output_pin));

// ==== test/tb.sv ====
`timescale 1ns/1ns
module tb;
	import ebt_pkg::*;
	logic       clk, rst_b, ctl_write, cmp_write, slow_prescale_select, slow_run_mode, ev_en, ff, port_latch;
	logic       fs_tick = 1'b0;
	logic [7:0] ctl_wdata, cmp_wdata, timer_control_reg, compare_value_reg, count_value, cv;
	logic       match_interrupt, divider_output_pin, event_input_pin;
	logic [15:0] rnd;
	int         failures, n_compared, t0, t1, k, j;
	int         cyc = 0;
	int         dv [6] = '{8, 32, 8, 16, 128, 128};
	logic [2:0] src [6] = '{SRC_DIV3, SRC_DIV5, SRC_DIV3, SRC_EVENT_PIN, SRC_SLOWEST, SRC_DIV7};
	logic [2:0] md [6] = '{MODE_TIMER, MODE_TIMER, MODE_DIVIDER, MODE_TIMER, MODE_DIVIDER, MODE_DIVIDER};
	ebt_timer u_ebt_timer (.clk(clk), .rst_b(rst_b), .ctl_write(ctl_write), .ctl_wdata(ctl_wdata),
		.cmp_write(cmp_write), .cmp_wdata(cmp_wdata), .fs_tick(fs_tick), .slow_prescale_select(slow_prescale_select),
		.slow_run_mode(slow_run_mode), .event_input_pin(event_input_pin), .timer_control_reg(timer_control_reg),
		.compare_value_reg(compare_value_reg), .count_value(count_value), .match_interrupt(match_interrupt),
		.divider_output_pin(divider_output_pin));
	ebt_event_src u_ebt_event_src (.clk(clk), .en(ev_en), .event_input_pin(event_input_pin));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fs_tick <= #5 (cyc % 16 == 0);
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task test_done;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	task wr(input logic c, input logic [7:0] d);
		@(posedge clk) #5;
		ctl_write = c;
		cmp_write = ~c;
		ctl_wdata = d;
		cmp_wdata = d;
		@(posedge clk) #5;
		ctl_write = 1'b0;
		cmp_write = 1'b0;
	endtask : wr
	task wm(output int t);
		int n;
		n = 0;
		@(posedge clk) #1;
		while (match_interrupt !== 1'b1 && n < 5000) begin
			@(posedge clk) #1;
			n++;
		end
		if (n >= 5000) begin
			failures++;
			test_done();
		end else begin
			t = cyc;
		end
	endtask : wm
	initial begin
		{rst_b, ctl_write, cmp_write, ev_en, slow_prescale_select, slow_run_mode} = '0;
		{ctl_wdata, cmp_wdata} = '0;
		{failures, n_compared} = '0;
		// Shared port latch set before the divider pin is used
		port_latch = 1'b1;
		rnd = 16'h0920;
		repeat (5) @(posedge clk);
		#5 rst_b = 1'b1;
		chk("ctl_reset", {8'h00, timer_control_reg}, {8'h00, CTL_RESET});
		chk("cmp_reset", {8'h00, compare_value_reg}, {8'h00, CMP_RESET});
		chk("pin_reset", {15'h0000, divider_output_pin}, 16'h0001);
		for (k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			cv = {4'h0, rnd[3:0] | 4'h1};
			ff = 1'b0;
			slow_prescale_select = (k == 4);
			slow_run_mode = (k == 4);
			ev_en = (k == 3);
			wr(1'b0, cv);
			chk("cmp_rd", {8'h00, compare_value_reg}, {8'h00, cv});
			wr(1'b1, {1'b0, src[k], 1'b0, md[k]});
			wr(1'b1, {1'b0, src[k], 1'b1, md[k]});
			chk("ctl_rd", {8'h00, timer_control_reg}, {8'h00, 1'b0, src[k], 1'b1, md[k]});
			for (j = 0; j < 4; j++) begin
				wm(t1);
				if (md[k] == MODE_DIVIDER) ff = ~ff;
				chk("pin", {15'h0000, port_latch & divider_output_pin}, {15'h0000, ~ff});
				if (j > 0) chk("period", 16'(t1 - t0), 16'(cv * dv[k]));
				t0 = t1;
			end
			// Separate writes: stop first, then force the pin
			wr(1'b1, {1'b0, src[k], 1'b0, md[k]});
			repeat (3) @(posedge clk);
			#5;
			chk("count_stop", {8'h00, count_value}, 16'h0000);
			chk("pin_hold", {15'h0000, divider_output_pin}, {15'h0000, ~ff});
			wr(1'b1, {1'b1, src[k], 1'b0, md[k]});
			repeat (3) @(posedge clk);
			#5;
			chk("pin_load", {15'h0000, divider_output_pin}, 16'h0000);
			wr(1'b1, {1'b0, src[k], 1'b0, md[k]});
			repeat (3) @(posedge clk);
			#5;
			chk("pin_high", {15'h0000, divider_output_pin}, 16'h0001);
		end
		test_done();
	end
endmodule : tb
